// ===== logic/capture_timer_pkg.sv
// Package with register map, field layout and types of the capture timer channels.
package capture_timer_pkg;

    localparam int NUM_CH = 2;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [9:0] TIMER2_MODE_IDX = 10'h1A2;
    localparam logic [9:0] TIMER3_MODE_IDX = 10'h1B2;
    localparam logic [9:0] COMPARE1_OFS    = 10'h002;
    localparam logic [9:0] CAPTURE0_OFS    = 10'h003;
    localparam logic [9:0] CAPTURE1_OFS    = 10'h004;
    localparam logic [9:0] COUNTER_OFS     = 10'h005;

    localparam int SOFT_CAPTURE_BIT = 5;

    typedef struct packed {
        logic       ff1_capture_invert_enable;
        logic       ff1_match_invert_enable;
        logic       soft_capture_trigger;
        logic [1:0] capture_timing_select;
        logic       match_clear_enable;
        logic [1:0] count_source_select;
    } mode_t;

    localparam logic [7:0]  MODE_RESET     = 8'h20;
    localparam logic [15:0] COUNTER_RESET  = 16'h0000;
    localparam logic [15:0] COMPARE_RESET  = 16'hFFFF;
    localparam logic [15:0] CAPTURE_RESET  = 16'h0000;

    localparam logic [1:0] SRC_PIN    = 2'b00;
    localparam logic [1:0] SRC_TAP1   = 2'b01;
    localparam logic [1:0] SRC_TAP4   = 2'b10;
    localparam logic [1:0] SRC_TAP16  = 2'b11;

    localparam logic [1:0] CAP_OFF        = 2'b00;
    localparam logic [1:0] CAP_TWO_PINS   = 2'b01;
    localparam logic [1:0] CAP_BOTH_EDGES = 2'b10;
    localparam logic [1:0] CAP_OTHER      = 2'b11;

    typedef enum logic [2:0] {
        KIND_NONE,
        KIND_MODE,
        KIND_COMPARE1,
        KIND_CAPTURE0,
        KIND_CAPTURE1,
        KIND_COUNTER
    } reg_kind_t;

    typedef struct packed {
        logic in0;
        logic in1;
    } pins_t;

    typedef struct packed {
        logic rise;
        logic fall;
    } edges_t;

endpackage

// ===== logic/sync_edge.sv
// Two-stage synchroniser with rising and falling edge detection for one pin.
`timescale 1ns/1ps
module sync_edge (
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    input  wire logic                      pin,
    output capture_timer_pkg::edges_t      edges
);
    import capture_timer_pkg::*;

    logic [2:0] sync_reg;
    logic [2:0] sync_next;

    always_comb begin
        sync_next = {sync_reg[1:0], pin};
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync_reg <= 3'h0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    // Stage 0 is read only by stage 1; edges compare stages 1 and 2.
    assign edges.rise = sync_reg[1] & ~sync_reg[2];
    assign edges.fall = ~sync_reg[1] & sync_reg[2];

endmodule

// ===== logic/capture_timer.sv
// Two 16-bit capture timer channels with mode registers on an Avalon-MM slave.
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
module capture_timer (
    input  wire logic                          sys_clk,
    input  wire logic                          rst,
    input  wire logic [11:0]                   avs_address,
    input  wire logic                          avs_read,
    input  wire logic                          avs_write,
    input  wire logic [31:0]                   avs_writedata,
    input  wire logic [3:0]                    avs_byteenable,
    output logic      [31:0]                   avs_readdata,
    output logic                               avs_waitrequest,
    input  capture_timer_pkg::pins_t [1:0]     timer_input,
    input  wire logic                          other_timer_output,
    input  wire logic                          prescale_tap_1,
    input  wire logic                          prescale_tap_4,
    input  wire logic                          prescale_tap_16,
    output logic                               timer2_capture_irq,
    output logic                               timer3_capture_irq,
    output logic      [1:0]                    ff1_capture_invert_enable,
    output logic      [1:0]                    ff1_match_invert_enable
);
    import capture_timer_pkg::*;
    // Indices below the base wrap to large offsets, so they never alias a register.
    function automatic reg_kind_t decode_reg(input logic [9:0] idx, input logic [9:0] base);
        case (idx - base)
            10'h000:      return KIND_MODE;
            COMPARE1_OFS: return KIND_COMPARE1;
            CAPTURE0_OFS: return KIND_CAPTURE0;
            CAPTURE1_OFS: return KIND_CAPTURE1;
            COUNTER_OFS:  return KIND_COUNTER;
            default:      return KIND_NONE;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait cycle, read data registered, write acts at the ack edge.

    logic        ack_reg;
    logic        ack_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [9:0]  idx;
    logic        aligned;
    logic        wr_fire;

    mode_t       mode_reg    [NUM_CH];
    logic [15:0] compare_reg [NUM_CH];
    logic [15:0] count_reg   [NUM_CH];
    logic [15:0] cap0_reg    [NUM_CH];
    logic [15:0] cap1_reg    [NUM_CH];
    logic [1:0]  irq_reg;

    assign idx             = avs_address[11:2];
    assign aligned         = (avs_address[1:0] == 2'b00);
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign wr_fire         = avs_write & ack_reg & aligned;
    assign avs_readdata    = rdata_reg;

    always_comb begin
        reg_kind_t k;
        k          = KIND_NONE;
        ack_next   = (avs_read | avs_write) & ~ack_reg;
        rdata_next = rdata_reg;
        if (avs_read && !ack_reg) begin
            rdata_next = 32'h0000_0000;
            for (int c = 0; c < NUM_CH; c++) begin
                k = decode_reg(idx, (c == 0) ? TIMER2_MODE_IDX : TIMER3_MODE_IDX);
                if (aligned) begin
                    unique case (k)
                        KIND_MODE:     rdata_next = rdata_next | {24'h0, mode_reg[c]};
                        KIND_COMPARE1: rdata_next = rdata_next | {16'h0, compare_reg[c]};
                        KIND_CAPTURE0: rdata_next = rdata_next | {16'h0, cap0_reg[c]};
                        KIND_CAPTURE1: rdata_next = rdata_next | {16'h0, cap1_reg[c]};
                        KIND_COUNTER:  rdata_next = rdata_next | {16'h0, count_reg[c]};
                        KIND_NONE:     rdata_next = rdata_next;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg   <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers, shared other timer output.

    edges_t other_edges;

    sync_edge u_other_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pin     (other_timer_output),
        .edges   (other_edges)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Channels: index 0 is timer 2, index 1 is timer 3.

    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
        localparam logic [9:0] BASE = (ch == 0) ? TIMER2_MODE_IDX : TIMER3_MODE_IDX;
        localparam bit HAS_OTHER = (ch == 0);

        edges_t      e0;
        edges_t      e1;
        reg_kind_t   kind;
        logic        tick;
        logic        match;
        logic        soft_cap;
        logic        hw_cap0;
        logic        hw_cap1;
        logic        irq_next;
        mode_t       mode_next;
        logic [15:0] compare_next;
        logic [15:0] count_next;
        logic [15:0] cap0_next;
        logic [15:0] cap1_next;

        sync_edge u_in0_sync (
            .sys_clk (sys_clk),
            .rst     (rst),
            .pin     (timer_input[ch].in0),
            .edges   (e0)
        );

        sync_edge u_in1_sync (
            .sys_clk (sys_clk),
            .rst     (rst),
            .pin     (timer_input[ch].in1),
            .edges   (e1)
        );

        assign kind = decode_reg(idx, BASE);

        always_comb begin
            mode_next    = mode_reg[ch];
            compare_next = compare_reg[ch];
            unique case (mode_reg[ch].count_source_select)
                SRC_PIN:   tick = e0.rise;
                SRC_TAP1:  tick = prescale_tap_1;
                SRC_TAP4:  tick = prescale_tap_4;
                SRC_TAP16: tick = prescale_tap_16;
            endcase
            match      = (count_reg[ch] == compare_reg[ch]);
            count_next = count_reg[ch];
            if (tick) begin
                if (mode_reg[ch].match_clear_enable && match) begin
                    count_next = COUNTER_RESET;
                end else begin
                    count_next = count_reg[ch] + 16'h0001;
                end
            end
            // Only a write of 1 over a held 1 is silent; the bit reads back as stored.
            soft_cap = wr_fire && (kind == KIND_MODE) && avs_byteenable[0]
                       && !(avs_writedata[SOFT_CAPTURE_BIT]
                            && mode_reg[ch].soft_capture_trigger);
            hw_cap0 = 1'b0;
            hw_cap1 = 1'b0;
            unique case (mode_reg[ch].capture_timing_select)
                CAP_OFF: begin
                    hw_cap0 = 1'b0;
                end
                CAP_TWO_PINS: begin
                    hw_cap0 = e0.rise;
                    hw_cap1 = e1.rise;
                end
                CAP_BOTH_EDGES: begin
                    hw_cap0 = e0.rise;
                    hw_cap1 = e0.fall;
                end
                CAP_OTHER: begin
                    hw_cap0 = HAS_OTHER && other_edges.rise;
                    hw_cap1 = HAS_OTHER && other_edges.fall;
                end
            endcase
            irq_next = (mode_reg[ch].capture_timing_select == CAP_BOTH_EDGES)
                       ? e0.fall : e0.rise;
            cap0_next = (soft_cap || hw_cap0) ? count_reg[ch] : cap0_reg[ch];
            cap1_next = hw_cap1 ? count_reg[ch] : cap1_reg[ch];
            if (wr_fire && (kind == KIND_MODE) && avs_byteenable[0]) begin
                mode_next = avs_writedata[7:0];
            end
            if (wr_fire && (kind == KIND_COMPARE1)) begin
                if (avs_byteenable[0]) compare_next[7:0] = avs_writedata[7:0];
                if (avs_byteenable[1]) compare_next[15:8] = avs_writedata[15:8];
            end
        end

        always_ff @(posedge sys_clk) begin
            if (rst) begin
                mode_reg[ch]    <= MODE_RESET;
                compare_reg[ch] <= COMPARE_RESET;
                count_reg[ch]   <= COUNTER_RESET;
                cap0_reg[ch]    <= CAPTURE_RESET;
                cap1_reg[ch]    <= CAPTURE_RESET;
                irq_reg[ch]     <= 1'b0;
            end else begin
                mode_reg[ch]    <= mode_next;
                compare_reg[ch] <= compare_next;
                count_reg[ch]   <= count_next;
                cap0_reg[ch]    <= cap0_next;
                cap1_reg[ch]    <= cap1_next;
                irq_reg[ch]     <= irq_next;
            end
        end

        assign ff1_capture_invert_enable[ch] = mode_reg[ch].ff1_capture_invert_enable;
        assign ff1_match_invert_enable[ch]   = mode_reg[ch].ff1_match_invert_enable;

        property p_tap_count;
            @(posedge sys_clk) disable iff (rst)
            (mode_reg[ch].count_source_select == SRC_TAP4) && prescale_tap_4 && !match
            |=> count_reg[ch] == $past(count_reg[ch]) + 16'h0001;
        endproperty
        a_tap_count: assert property (p_tap_count) else $error("tap count missed");
        property p_match_clear;
            @(posedge sys_clk) disable iff (rst)
            tick && mode_reg[ch].match_clear_enable && match |=> count_reg[ch] == 16'h0000;
        endproperty
        a_match_clear: assert property (p_match_clear) else $error("no clear");
        property p_no_clear;
            @(posedge sys_clk) disable iff (rst)
            tick && !mode_reg[ch].match_clear_enable && match && count_reg[ch] != 16'hFFFF
            |=> count_reg[ch] != 16'h0000;
        endproperty
        a_no_clear: assert property (p_no_clear) else $error("spurious clear");
        property p_cap_off;
            @(posedge sys_clk) disable iff (rst)
            (mode_reg[ch].capture_timing_select == CAP_OFF) && !wr_fire
            |=> $stable(cap0_reg[ch]) && $stable(cap1_reg[ch]);
        endproperty
        a_cap_off: assert property (p_cap_off) else $error("capture while off");
        property p_pin_rise;
            @(posedge sys_clk) disable iff (rst)
            (mode_reg[ch].capture_timing_select == CAP_TWO_PINS) && $rose(timer_input[ch].in1)
            ##2 1 |=> cap1_reg[ch] == $past(count_reg[ch]);
        endproperty
        a_pin_rise: assert property (p_pin_rise) else $error("no in1 capture");
        property p_fall_cap;
            @(posedge sys_clk) disable iff (rst)
            (mode_reg[ch].capture_timing_select == CAP_BOTH_EDGES) && e0.fall
            |=> cap1_reg[ch] == $past(count_reg[ch]);
        endproperty
        a_fall_cap: assert property (p_fall_cap) else $error("no fall capture");
        property p_other_cap;
            @(posedge sys_clk) disable iff (rst)
            (mode_reg[ch].capture_timing_select == CAP_OTHER) && other_edges.fall
            |=> cap1_reg[ch] == (HAS_OTHER ? $past(count_reg[ch]) : $past(cap1_reg[ch]));
        endproperty
        a_other_cap: assert property (p_other_cap) else $error("other capture");
        property p_irq_edge;
            @(posedge sys_clk) disable iff (rst)
            (mode_reg[ch].capture_timing_select == CAP_BOTH_EDGES) ? e0.fall : e0.rise
            |=> irq_reg[ch];
        endproperty
        a_irq_edge: assert property (p_irq_edge) else $error("irq missed");
        property p_soft_cap;
            @(posedge sys_clk) disable iff (rst)
            wr_fire && kind == KIND_MODE && avs_byteenable[0]
            && (!avs_writedata[SOFT_CAPTURE_BIT] || !mode_reg[ch].soft_capture_trigger)
            |=> cap0_reg[ch] == $past(count_reg[ch]);
        endproperty
        a_soft_cap: assert property (p_soft_cap) else $error("no soft capture");
        c_clear: cover property (@(posedge sys_clk) disable iff (rst)
            tick && mode_reg[ch].match_clear_enable && match);
        c_soft: cover property (@(posedge sys_clk) disable iff (rst) soft_cap);
        c_fall: cover property (@(posedge sys_clk) disable iff (rst) hw_cap1 && e0.fall);
    end

    assign timer2_capture_irq = irq_reg[0];
    assign timer3_capture_irq = irq_reg[1];
    property p_bus_answer;
        @(posedge sys_clk) disable iff (rst)
        (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");
endmodule

// ===== verification/pin_source_model.sv
// Far-side model: timer input pins, other timer output and prescaler taps.
`timescale 1ns/1ps
module pin_source_model (
    input  wire logic                      sys_clk,
    output capture_timer_pkg::pins_t [1:0] timer_input,
    output logic                           other_timer_output,
    output logic                           prescale_tap_1,
    output logic                           prescale_tap_4,
    output logic                           prescale_tap_16
);
    import capture_timer_pkg::*;

    initial begin
        timer_input = '0;
        other_timer_output = 1'b0;
        prescale_tap_1 = 1'b0;
        prescale_tap_4 = 1'b0;
        prescale_tap_16 = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Taps stand still between bursts so that counters freeze while software reads them.
    task automatic run_ticks(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            prescale_tap_1  <= 1'b1;
            prescale_tap_4  <= (i % 4 == 3);
            prescale_tap_16 <= (i % 16 == 15);
        end
        @(posedge sys_clk);
        prescale_tap_1  <= 1'b0;
        prescale_tap_4  <= 1'b0;
        prescale_tap_16 <= 1'b0;
    endtask

    // Levels are held five cycles, so synchroniser, capture and interrupt have all landed.
    task automatic set_pin(input int ch, input int which, input logic v);
        @(posedge sys_clk);
        if (which == 0) begin
            timer_input[ch].in0 <= v;
        end else if (which == 1) begin
            timer_input[ch].in1 <= v;
        end else begin
            other_timer_output <= v;
        end
        repeat (5) @(posedge sys_clk);
    endtask
endmodule

// ===== verification/timer_capture_mode_control_test.sv
// Self-checking bench for the capture timer channels over the register bus.
`timescale 1ns/1ps
module timer_capture_mode_control_test;
    import capture_timer_pkg::*;

    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [11:0] avs_address = '0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    pins_t [1:0] timer_input;
    logic        other_out;
    logic [2:0]  taps;
    logic [1:0]  irq;
    logic [1:0]  ff1_cap;
    logic [1:0]  ff1_match;
    int          error_cnt = 0;
    int          n_checks = 0;
    int          irq_cnt [2] = '{0, 0};
    int          base;
    logic [15:0] cnt_exp [2] = '{16'h0000, 16'h0000};
    logic [15:0] cap_exp [2][2] = '{default: 16'h0000};
    logic [15:0] held;
    logic [31:0] rd;
    logic [9:0]  rst_ofs [5] = '{10'h000, COMPARE1_OFS, CAPTURE0_OFS, CAPTURE1_OFS, COUNTER_OFS};
    logic [31:0] rst_val [5] = '{32'h00000020, 32'h0000FFFF, 32'h0, 32'h0, 32'h0};

    always #12.5 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        irq_cnt[0] <= irq_cnt[0] + int'(irq[0] === 1'b1);
        irq_cnt[1] <= irq_cnt[1] + int'(irq[1] === 1'b1);
    end

    capture_timer capture_timer_inst (
        .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .timer_input(timer_input), .other_timer_output(other_out),
        .prescale_tap_1(taps[0]), .prescale_tap_4(taps[1]), .prescale_tap_16(taps[2]),
        .timer2_capture_irq(irq[0]), .timer3_capture_irq(irq[1]),
        .ff1_capture_invert_enable(ff1_cap), .ff1_match_invert_enable(ff1_match)
    );

    pin_source_model pin_source_model_inst (
        .sys_clk(sys_clk), .timer_input(timer_input), .other_timer_output(other_out),
        .prescale_tap_1(taps[0]), .prescale_tap_4(taps[1]), .prescale_tap_16(taps[2])
    );

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [11:0] reg_addr(input int ch, input logic [9:0] ofs);
        return {(ch == 0 ? TIMER2_MODE_IDX : TIMER3_MODE_IDX) + ofs, 2'b00};
    endfunction

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One bus cycle; the request stands until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_write      <= wr;
        avs_read       <= !wr;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (n >= 50) begin
            error_cnt++;
            final_report();
        end
    endtask

    task automatic rd_chk(input int ch, input logic [9:0] ofs, input logic [31:0] exp,
                          input string what);
        bus(1'b0, reg_addr(ch, ofs), 32'h0, 4'hF);
        check(rd, exp, what);
    endtask

    task automatic adv(input int n);
        pin_source_model_inst.run_ticks(n);
        cnt_exp[0] += 16'(n);
        cnt_exp[1] += 16'(n);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        for (int ch = 0; ch < 2; ch++) begin
            for (int k = 0; k < 5; k++) rd_chk(ch, rst_ofs[k], rst_val[k], "reset value");
        end
        // Unmapped, misaligned and wrong-lane accesses must leave everything alone.
        bus(1'b1, 12'h000, 32'hFF, 4'hF);
        bus(1'b0, 12'h689, 32'h0, 4'hF);
        check(rd, 32'h0, "misaligned read");
        bus(1'b1, reg_addr(0, 0), 32'h00, 4'h2);
        rd_chk(0, 0, 32'h20, "mode after lane 1 write");
        rd_chk(0, CAPTURE0_OFS, 32'h0, "no capture from ignored write");

        bus(1'b1, reg_addr(0, COMPARE1_OFS), 32'h3, 4'h3);
        bus(1'b1, reg_addr(0, 0), 32'h25, 4'h1);
        pin_source_model_inst.run_ticks(10);
        rd_chk(0, COUNTER_OFS, 32'h2, "count with clear");
        bus(1'b1, reg_addr(0, 0), 32'h21, 4'h1);
        pin_source_model_inst.run_ticks(10);
        rd_chk(0, COUNTER_OFS, 32'hC, "count without clear");
        cnt_exp[0] = 16'h000C;

        for (int s = 1; s < 4; s++) begin
            bus(1'b1, reg_addr(0, 0), 32'h20 | s, 4'h1);
            pin_source_model_inst.run_ticks(64);
            cnt_exp[0] += 16'(64 >> (2 * (s - 1)));
            rd_chk(0, COUNTER_OFS, {16'h0, cnt_exp[0]}, "tap count");
        end
        bus(1'b1, reg_addr(0, 0), 32'h20, 4'h1);
        repeat (4) begin
            pin_source_model_inst.set_pin(0, 0, 1'b1);
            pin_source_model_inst.set_pin(0, 0, 1'b0);
        end
        cnt_exp[0] += 16'h0004;
        rd_chk(0, COUNTER_OFS, {16'h0, cnt_exp[0]}, "pin count");

        // Counters move only between pin events, so each capture value is known exactly.
        bus(1'b1, reg_addr(1, 0), 32'h21, 4'h1);
        for (int ch = 0; ch < 2; ch++) begin
            for (int code = 0; code < 4; code++) begin
                bus(1'b1, reg_addr(ch, 0), 32'h21 | (code << 3), 4'h1);
                base = irq_cnt[ch];
                for (int ev = 0; ev < 6; ev++) begin
                    adv(5);
                    pin_source_model_inst.set_pin(ch, ev / 2, (ev % 2) == 0);
                    if ((ev == 0 && (code == 1 || code == 2)) || (ev == 4 && code == 3 && ch == 0))
                        cap_exp[ch][0] = cnt_exp[ch];
                    if ((ev == 2 && code == 1) || (ev == 1 && code == 2) ||
                        (ev == 5 && code == 3 && ch == 0))
                        cap_exp[ch][1] = cnt_exp[ch];
                    if (ev < 2)
                        check(irq_cnt[ch] - base, 32'(ev == 1 || code != 2), "irq");
                end
                rd_chk(ch, CAPTURE0_OFS, {16'h0, cap_exp[ch][0]}, "cap0");
                rd_chk(ch, CAPTURE1_OFS, {16'h0, cap_exp[ch][1]}, "cap1");
            end
        end

        bus(1'b1, reg_addr(0, 0), 32'h01, 4'h1);
        rd_chk(0, CAPTURE0_OFS, {16'h0, cnt_exp[0]}, "soft capture on 0");
        adv(3);
        bus(1'b1, reg_addr(0, 0), 32'h21, 4'h1);
        rd_chk(0, CAPTURE0_OFS, {16'h0, cnt_exp[0]}, "soft capture on 1");
        held = cnt_exp[0];
        adv(3);
        bus(1'b1, reg_addr(0, 0), 32'hE1, 4'h1);
        rd_chk(0, CAPTURE0_OFS, {16'h0, held}, "no soft capture");
        check({30'h0, ff1_cap}, 32'h1, "ff1 capture invert");
        check({30'h0, ff1_match}, 32'h1, "ff1 match invert");
        rd_chk(0, 0, 32'hE1, "mode readback");
        final_report();
    end
endmodule
